// File: dvm_core_model.sv
// dvm_core_model: the core's load/store stream, one access per call.
// assumes the bench calls issue() and waits until it returns.
`timescale 1ns/10ps
`default_nettype none

module dvm_core_model (
    // clock
    input  wire logic                   pclk,
    // executed access
    output var dvm_pkg::dvm_access_type acc
);
    initial acc = '0;

    // reported once, after the transfer, with the word-aligned data moved
    task automatic issue(input logic st, input logic [31:0] a,
                         input logic [31:0] d);
        @(posedge pclk);
        acc <= '{1'b1, st, a, d};
        @(posedge pclk);
        // stale lanes are inverted so a late sample cannot pass
        acc <= '{1'b0, st, ~a, ~d};
    endtask
endmodule // dvm_core_model

`default_nettype wire

// File: dvm_lane_cmp.sv
// dvm_lane_cmp: byte-lane value comparison for one channel.
// assumes data lanes are already word aligned; purely combinational.
`timescale 1ns/10ps
`default_nettype none

module dvm_lane_cmp #(
    parameter int unsigned LANES = 4
) (
    // operands
    input  wire logic [8*LANES-1:0]       ref_val,
    input  wire logic [8*LANES-1:0]       data,
    // selection
    input  wire logic [LANES-1:0]         lane_sel,
    input  wire dvm_pkg::dvm_cmp_mode_type mode,
    // result
    output logic                          pass
);

    logic [LANES-1:0] eq;
    logic [LANES-1:0] hit;
    logic [LANES-1:0] ok;

    // halfword pairing is fixed to four lanes
    if (LANES != 4) begin : g_bad_lanes
        $error("dvm_lane_cmp supports four byte lanes only");
    end

    for (genvar k = 0; k < LANES; k++) begin : g_lane
        assign eq[k]  = ref_val[8*k +: 8] == data[8*k +: 8];
        assign hit[k] = lane_sel[k] & eq[k];
        assign ok[k]  = ~lane_sel[k] | eq[k];
    end

    always_comb begin
        case (mode)
            dvm_pkg::CMP_AND:   pass = &ok;
            dvm_pkg::CMP_OR:    pass = |hit;
            dvm_pkg::CMP_ANDOR: pass = (hit[0] & hit[1]) |
                                       (hit[2] & hit[3]);
            default:            pass = 1'b0;
        endcase
    end

endmodule // dvm_lane_cmp

`default_nettype wire

// File: dvm_pkg.sv
// dvm_pkg: register map, field layout, reset values and carrier types
// for the data value compare debug block.
// assumes a 32-bit apb register port and a core that reports each
// executed load or store once, with its word-aligned data lanes.
`default_nettype none

package dvm_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ADDR_A = 8'h04;
    localparam logic [7:0] OFF_ADDR_B = 8'h08;
    localparam logic [7:0] OFF_VAL_A  = 8'h0C;
    localparam logic [7:0] OFF_VAL_B  = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    // debug_ctrl_one field positions, channel b sits one field above a
    localparam int RD_EN_LSB  = 0;
    localparam int WR_EN_LSB  = 2;
    localparam int RANGE_BIT  = 4;
    localparam int EXCL_BIT   = 5;
    localparam int SIZE_LSB   = 6;
    localparam int BE_LSB     = 10;
    localparam int MODE_LSB   = 18;
    localparam logic [31:0] CTRL_WMASK = 32'h003F_FFFF;

    // debug_event_status bit positions
    localparam int ST_RD_LSB = 0;
    localparam int ST_WR_LSB = 2;
    localparam int ST_LATE   = 4;
    localparam int ST_PEND   = 5;

    // values after reset
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] WORD_RST   = 32'h0000_0000;
    localparam logic [5:0]  STATUS_RST = 6'h00;

    // exact-compare granularity
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [31:0] MASK_BYTE = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_HALF = 32'hFFFF_FFFE;
    localparam logic [31:0] MASK_WORD = 32'hFFFF_FFFC;
    localparam logic [31:0] MASK_LINE = 32'hFFFF_FFE0;

    typedef enum logic [1:0] {
        CMP_NONE  = 2'b00,
        CMP_AND   = 2'b01,
        CMP_OR    = 2'b10,
        CMP_ANDOR = 2'b11
    } dvm_cmp_mode_type;

    // one executed load or store, as reported by the core
    typedef struct packed {
        logic        valid;
        logic        store;
        logic [31:0] addr;
        logic [31:0] data;
    } dvm_access_type;

endpackage

`default_nettype wire

// File: dvm_value_debug.sv
// dvm_value_debug: data address and data value compare debug events,
// sticky status flags, late-event flag and debug interrupt request.
// assumes apb master on pclk and a core that presents each executed
// load/store for one cycle with acc.valid, after the data has moved.
//
// Notes on behaviour
// - value event needs address match and value match on same access
// - events judged after execution, using the data actually moved
// - enabled value compare replaces the plain address event
// - value compare enabled by read/write enable plus nonzero lanes
// - each byte-enable bit selects one lane of the value register
// - value events use the same exact or range address match
// - value hit sets read flag on load, write flag on store
// - status flags stay set until software clears them
// - without value compare, address hit sets enabled flags
// - value mismatch leaves both channel flags unchanged
// - mode 01: every selected lane must match
// - mode 10: at least one selected lane must match
// - mode 11: lanes 0 and 1 match, or lanes 2 and 3 match
// - event while interrupts disallowed sets late flag, defers interrupt
// - pending event raises interrupt once the allow bit returns
// - inclusive range: first address inclusive up to second exclusive
// - exclusive range: at or below first, or at or above second
// - exact mode ignores low address bits per size field
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module dvm_value_debug (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // core load/store stream and debug interrupt allow
    input  wire dvm_pkg::dvm_access_type acc,
    input  wire logic                  dbg_irq_allow,
    // debug interrupt request, one cycle
    output logic                       dbg_irq_take
);

    localparam int CH = 2;

    logic [31:0]      debug_ctrl_one_q;
    logic [31:0]      dac_q [CH];
    logic [31:0]      value_match_reg_q [CH];
    logic [5:0]       status_q;
    logic [5:0]       status_d;

    logic             setup;
    logic             access;
    logic             wr_acc;
    logic [CH-1:0]    rd_en;
    logic [CH-1:0]    wr_en;
    logic [CH-1:0]    vc_en;
    logic [CH-1:0]    ahit;
    logic [CH-1:0]    vpass;
    logic [CH-1:0]    rd_set;
    logic [CH-1:0]    wr_set;
    logic             pair_range_select;
    logic             range_exclusive_select;
    logic             range_hit;
    logic             any_ev;
    logic             take;
    logic [5:0]       clr;

    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            dvm_pkg::OFF_CTRL, dvm_pkg::OFF_ADDR_A, dvm_pkg::OFF_ADDR_B,
            dvm_pkg::OFF_VAL_A, dvm_pkg::OFF_VAL_B,
            dvm_pkg::OFF_STATUS: addr_known = 1'b1;
            default:             addr_known = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] size_mask(input logic [1:0] sz);
        case (sz)
            dvm_pkg::SIZE_BYTE: size_mask = dvm_pkg::MASK_BYTE;
            dvm_pkg::SIZE_HALF: size_mask = dvm_pkg::MASK_HALF;
            dvm_pkg::SIZE_WORD: size_mask = dvm_pkg::MASK_WORD;
            default:            size_mask = dvm_pkg::MASK_LINE;
        endcase
    endfunction

    // apb decode; slave answers in the access cycle, no wait states
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr_acc = access & pwrite & addr_known(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~addr_known(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= dvm_pkg::WORD_RST;
        end else if (setup && !pwrite) begin
            case (paddr)
                dvm_pkg::OFF_CTRL:   prdata <= debug_ctrl_one_q;
                dvm_pkg::OFF_ADDR_A: prdata <= dac_q[0];
                dvm_pkg::OFF_ADDR_B: prdata <= dac_q[1];
                dvm_pkg::OFF_VAL_A:  prdata <= value_match_reg_q[0];
                dvm_pkg::OFF_VAL_B:  prdata <= value_match_reg_q[1];
                dvm_pkg::OFF_STATUS: prdata <= {26'h0, status_q};
                default:             prdata <= dvm_pkg::WORD_RST;
            endcase
        end else begin
            prdata <= dvm_pkg::WORD_RST;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_ctrl_one_q     <= dvm_pkg::CTRL_RST;
            dac_q[0]             <= dvm_pkg::WORD_RST;
            dac_q[1]             <= dvm_pkg::WORD_RST;
            value_match_reg_q[0] <= dvm_pkg::WORD_RST;
            value_match_reg_q[1] <= dvm_pkg::WORD_RST;
        end else if (wr_acc) begin
            case (paddr)
                dvm_pkg::OFF_CTRL:
                    debug_ctrl_one_q <= pwdata & dvm_pkg::CTRL_WMASK;
                dvm_pkg::OFF_ADDR_A: dac_q[0]             <= pwdata;
                dvm_pkg::OFF_ADDR_B: dac_q[1]             <= pwdata;
                dvm_pkg::OFF_VAL_A:  value_match_reg_q[0] <= pwdata;
                dvm_pkg::OFF_VAL_B:  value_match_reg_q[1] <= pwdata;
                default: ;
            endcase
        end
    end

    assign pair_range_select      = debug_ctrl_one_q[dvm_pkg::RANGE_BIT];
    assign range_exclusive_select = debug_ctrl_one_q[dvm_pkg::EXCL_BIT];

    // range compare shares both address registers between channels
    always_comb begin
        if (range_exclusive_select) begin
            range_hit = (acc.addr <= dac_q[0]) ||
                        (acc.addr >= dac_q[1]);
        end else begin
            range_hit = (acc.addr >= dac_q[0]) &&
                        (acc.addr <  dac_q[1]);
        end
    end

    for (genvar c = 0; c < CH; c++) begin : g_ch
        logic [1:0] match_size;
        logic [3:0] byte_lane_sel;
        logic [1:0] compare_mode;
        logic [31:0] mask;

        assign rd_en[c] = debug_ctrl_one_q[dvm_pkg::RD_EN_LSB + c];
        assign wr_en[c] = debug_ctrl_one_q[dvm_pkg::WR_EN_LSB + c];
        assign match_size    = debug_ctrl_one_q[dvm_pkg::SIZE_LSB + 2*c +: 2];
        assign byte_lane_sel = debug_ctrl_one_q[dvm_pkg::BE_LSB + 4*c +: 4];
        assign compare_mode  = debug_ctrl_one_q[dvm_pkg::MODE_LSB + 2*c +: 2];
        assign mask          = size_mask(match_size);

        // size field is ignored while the pair forms a range
        assign ahit[c] = pair_range_select ? range_hit :
            ((acc.addr & mask) == (dac_q[c] & mask));
        assign vc_en[c] = (rd_en[c] | wr_en[c]) & (|byte_lane_sel);

        dvm_lane_cmp #(
            .LANES (4)
        ) u_cmp (
            .ref_val  (value_match_reg_q[c]),
            .data     (acc.data),
            .lane_sel (byte_lane_sel),
            .mode     (dvm_pkg::dvm_cmp_mode_type'(compare_mode)),
            .pass     (vpass[c])
        );

        // value compare replaces the plain address event
        assign rd_set[c] = acc.valid & ~acc.store & rd_en[c] & ahit[c] &
                           (~vc_en[c] | vpass[c]);
        assign wr_set[c] = acc.valid & acc.store & wr_en[c] & ahit[c] &
                           (~vc_en[c] | vpass[c]);
    end

    // status: set wins over a same-cycle write-one-to-clear
    assign clr = (wr_acc && paddr == dvm_pkg::OFF_STATUS) ?
                 {1'b0, pwdata[4:0]} : 6'h00;
    assign any_ev = |{rd_set, wr_set};
    // deferred event is delivered as soon as the core allows it
    assign take = dbg_irq_allow & (any_ev | status_q[dvm_pkg::ST_PEND]);

    always_comb begin
        status_d = status_q & ~clr;
        status_d[dvm_pkg::ST_RD_LSB +: 2] =
            status_d[dvm_pkg::ST_RD_LSB +: 2] | rd_set;
        status_d[dvm_pkg::ST_WR_LSB +: 2] =
            status_d[dvm_pkg::ST_WR_LSB +: 2] | wr_set;
        if (any_ev && !dbg_irq_allow) begin
            status_d[dvm_pkg::ST_LATE] = 1'b1;
            status_d[dvm_pkg::ST_PEND] = 1'b1;
        end else if (take) begin
            status_d[dvm_pkg::ST_PEND] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= dvm_pkg::STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_irq_take <= 1'b0;
        end else begin
            dbg_irq_take <= take;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_value_needs_both: assert property (
        acc.valid && acc.store && vc_en[0] && wr_en[0] &&
        !(ahit[0] && vpass[0]) && !clr[dvm_pkg::ST_WR_LSB]
        |=> $stable(status_q[dvm_pkg::ST_WR_LSB]))
        else $error("write flag a moved without address and value hit");

    a_read_flag_set: assert property (
        acc.valid && !acc.store && rd_en[1] && ahit[1] &&
        (!vc_en[1] || vpass[1])
        |=> status_q[dvm_pkg::ST_RD_LSB + 1])
        else $error("read flag b not set on qualifying load");

    a_value_blocks_flags: assert property (
        vc_en[0] && ahit[0] && !vpass[0] && clr == 6'h00
        |=> $stable({status_q[dvm_pkg::ST_WR_LSB],
                     status_q[dvm_pkg::ST_RD_LSB]}))
        else $error("value mismatch changed channel flags");

    a_flags_sticky: assert property (
        !any_ev && clr == 6'h00 ##1 !any_ev && clr == 6'h00
        |=> status_q[3:0] == $past(status_q[3:0], 2))
        else $error("status flags changed without event or clear");

    a_late_event_set: assert property (
        any_ev && !dbg_irq_allow
        |=> status_q[dvm_pkg::ST_LATE] && !dbg_irq_take)
        else $error("late flag missing or interrupt taken while masked");

    a_pending_taken: assert property (
        status_q[dvm_pkg::ST_PEND] && dbg_irq_allow
        |=> dbg_irq_take && !status_q[dvm_pkg::ST_PEND])
        else $error("pending debug event not delivered");

    a_range_incl: assert property (
        pair_range_select && !range_exclusive_select && ahit[0]
        |-> acc.addr >= dac_q[0] && acc.addr < dac_q[1])
        else $error("inclusive range hit outside range");

    a_range_excl: assert property (
        pair_range_select && range_exclusive_select &&
        acc.addr > dac_q[0] && acc.addr < dac_q[1] |-> !ahit[1])
        else $error("exclusive range hit inside gap");

    a_mode_none_fails: assert property (
        debug_ctrl_one_q[dvm_pkg::MODE_LSB +: 2] == 2'b00 |-> !vpass[0])
        else $error("mode zero passed value compare");

    a_andor_pairs: assert property (
        debug_ctrl_one_q[dvm_pkg::MODE_LSB +: 2] == 2'b11 &&
        debug_ctrl_one_q[dvm_pkg::BE_LSB +: 4] == 4'hF &&
        acc.data[15:0] == value_match_reg_q[0][15:0] |-> vpass[0])
        else $error("halfword pair match not passed");

    a_apb_answer: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one access cycle");

    c_value_write_hit: cover property (
        acc.valid && acc.store && vc_en[0] && wr_set[0]);
    c_deferred_event: cover property (
        any_ev && !dbg_irq_allow ##[1:20] dbg_irq_take);
    c_set_over_clear: cover property (
        any_ev && clr != 6'h00);
    c_exclusive_range: cover property (
        pair_range_select && range_exclusive_select && |rd_set);

endmodule // dvm_value_debug

`default_nettype wire

// File: dvm_value_debug_tb_top.sv
// dvm_value_debug_tb_top: self-checking bench for dvm_value_debug.
// assumes the core model drives acc and this bench is the apb master.
`timescale 1ns/10ps
`default_nettype none

module dvm_value_debug_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dbg_irq_allow = 1'b1;
    logic        dbg_irq_take;
    logic [31:0] rd;
    logic        err;
    int          failures = 0;
    int          check_count = 0;
    dvm_pkg::dvm_access_type acc;

    localparam logic [31:0] RDA = 32'h1;
    localparam logic [31:0] RDB = 32'h2;
    localparam logic [31:0] WRA = 32'h4;
    localparam logic [31:0] RNG = 32'h10;
    // mode, lanes, data; hit flags below, entry 0 at bit 0
    localparam logic [37:0] VT [9] = '{
        {2'b01, 4'hF, 32'h4433_2211}, {2'b01, 4'h5, 32'h5533_5511},
        {2'b01, 4'hF, 32'h4433_2210}, {2'b10, 4'h8, 32'h0000_0000},
        {2'b10, 4'hF, 32'h0033_0000}, {2'b11, 4'hF, 32'h0000_2211},
        {2'b11, 4'hF, 32'h4433_0000}, {2'b11, 4'hF, 32'h4400_2200},
        {2'b00, 4'hF, 32'h4433_2211}};
    localparam logic [8:0] VHIT = 9'h073;
    // exclusive, address, hit
    localparam logic [33:0] RT [8] = '{
        {1'b0, 32'h0000_0FFF, 1'b0}, {1'b0, 32'h0000_1000, 1'b1},
        {1'b0, 32'h0000_1FFF, 1'b1}, {1'b0, 32'h0000_2000, 1'b0},
        {1'b1, 32'h0000_1000, 1'b1}, {1'b1, 32'h0000_1001, 1'b0},
        {1'b1, 32'h0000_2000, 1'b1}, {1'b1, 32'hFFFF_FFFF, 1'b1}};

    always #20 pclk = ~pclk;

    dvm_value_debug dvm_value_debug_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .acc(acc),
        .dbg_irq_allow(dbg_irq_allow), .dbg_irq_take(dbg_irq_take));

    dvm_core_model dvm_core_model_i (.pclk(pclk), .acc(acc));

    task automatic test_done;
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            test_done();
        end
    endtask

    // one access, then the status word against the expected one
    task automatic ev(input logic st, input logic [31:0] a,
                      input logic [31:0] d, input logic [31:0] exp);
        dvm_core_model_i.issue(st, a, d);
        apb(1'b0, dvm_pkg::OFF_STATUS, 32'h0);
        chk(rd, exp);
    endtask

    task automatic t_reset;
        apb(1'b0, dvm_pkg::OFF_CTRL, 32'h0);
        chk(rd, dvm_pkg::CTRL_RST);
        apb(1'b0, dvm_pkg::OFF_STATUS, 32'h0);
        chk(rd, {26'h0, dvm_pkg::STATUS_RST});
        apb(1'b0, 8'h18, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, dvm_pkg::OFF_CTRL, 32'hFFFF_FFFF);
        apb(1'b0, dvm_pkg::OFF_CTRL, 32'h0);
        chk(rd, dvm_pkg::CTRL_WMASK);
    endtask

    task automatic t_exact;
        apb(1'b1, dvm_pkg::OFF_ADDR_A, 32'h0000_1000);
        apb(1'b1, dvm_pkg::OFF_CTRL, RDA);
        ev(1'b0, 32'h0000_1001, 32'h0, 32'h0);
        apb(1'b1, dvm_pkg::OFF_CTRL, RDA | (32'h1 << dvm_pkg::SIZE_LSB));
        ev(1'b0, 32'h0000_1002, 32'h0, 32'h0);
        ev(1'b0, 32'h0000_1001, 32'h0, 32'h1);
        apb(1'b1, dvm_pkg::OFF_STATUS, 32'h1F);
        apb(1'b1, dvm_pkg::OFF_CTRL, RDA | (32'h3 << dvm_pkg::SIZE_LSB));
        ev(1'b0, 32'h0000_101C, 32'h0, 32'h1);
        // store with write compare off: read flag only persists
        ev(1'b1, 32'h0000_1000, 32'h0, 32'h1);
        apb(1'b1, dvm_pkg::OFF_CTRL, WRA | (32'h2 << dvm_pkg::SIZE_LSB));
        ev(1'b1, 32'h0000_1000, 32'h0, 32'h5);
    endtask

    task automatic t_value;
        logic [31:0] exp;
        apb(1'b1, dvm_pkg::OFF_VAL_A, 32'h4433_2211);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, dvm_pkg::OFF_CTRL, RDA | WRA
                | (32'h2 << dvm_pkg::SIZE_LSB)
                | (32'(VT[i][35:32]) << dvm_pkg::BE_LSB)
                | (32'(VT[i][37:36]) << dvm_pkg::MODE_LSB));
            apb(1'b1, dvm_pkg::OFF_STATUS, 32'h1F);
            exp = VHIT[i] ? (i[0] ? 32'h4 : 32'h1) : 32'h0;
            ev(i[0], 32'h0000_1002, VT[i][31:0], exp);
        end
    endtask

    task automatic t_range;
        apb(1'b1, dvm_pkg::OFF_ADDR_B, 32'h0000_2000);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, dvm_pkg::OFF_CTRL,
                RDB | RNG | (32'(RT[i][33]) << dvm_pkg::EXCL_BIT));
            apb(1'b1, dvm_pkg::OFF_STATUS, 32'h1F);
            ev(1'b0, RT[i][32:1], 32'h0, {30'h0, RT[i][0], 1'b0});
        end
        // channel b value compare on an exact word match, store side
        apb(1'b1, dvm_pkg::OFF_VAL_B, 32'h8877_6655);
        apb(1'b1, dvm_pkg::OFF_CTRL, 32'h8
            | (32'h2 << (dvm_pkg::SIZE_LSB + 2))
            | (32'hF << (dvm_pkg::BE_LSB + 4))
            | (32'h1 << (dvm_pkg::MODE_LSB + 2)));
        apb(1'b1, dvm_pkg::OFF_STATUS, 32'h1F);
        ev(1'b1, 32'h0000_2000, 32'h8877_6654, 32'h0);
        ev(1'b1, 32'h0000_2000, 32'h8877_6655, 32'h8);
    endtask

    task automatic t_late;
        apb(1'b1, dvm_pkg::OFF_CTRL, RDA | (32'h2 << dvm_pkg::SIZE_LSB));
        apb(1'b1, dvm_pkg::OFF_STATUS, 32'h1F);
        @(posedge pclk);
        dbg_irq_allow <= 1'b0;
        ev(1'b0, 32'h0000_1000, 32'h0, 32'h31);
        chk(32'(dbg_irq_take), 32'h0);
        @(posedge pclk);
        dbg_irq_allow <= 1'b1;
        @(posedge pclk);
        #1;
        chk(32'(dbg_irq_take), 32'h1);
        apb(1'b0, dvm_pkg::OFF_STATUS, 32'h0);
        chk(rd, 32'h11);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_exact();
        t_value();
        t_range();
        t_late();
        test_done();
    end
endmodule // dvm_value_debug_tb_top

`default_nettype wire
